// ===== irqp_top.sv
/*
 * Priority configuration block for 23 peripheral interrupt sources: three
 * 16-bit priority registers, read-only views of the sorted requests, a
 * sticky record of requests that hit a disabled source, and the router.
 * Assumes source requests are levels from logic on CLK, and a register
 * master that strobes for one cycle and takes read data the next cycle.
 */
module irqp_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [irqp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [irqp_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [irqp_pkg::DATA_W-1:0] RDATA,
    // Peripheral requests
    input wire logic [irqp_pkg::NUM_SRC-1:0] SRC_REQ,
    // Prioritised requests toward the core
    output logic [irqp_pkg::NUM_SRC-1:0] LVL0_REQ,
    output logic [irqp_pkg::NUM_SRC-1:0] LVL1_REQ,
    output logic [irqp_pkg::NUM_SRC-1:0] LVL2_REQ,
    output logic [2:0] LVL_ANY,
    output logic [1:0] LVL_TOP
);
    import irqp_pkg::*;

    // Configuration registers
    logic [15:0] timer_prio_q;
    logic [15:0] timer_prio_d;
    logic [15:0] serial_prio_q;
    logic [15:0] serial_prio_d;
    logic [15:0] pwm_adc_prio_q;
    logic [15:0] pwm_adc_prio_d;
    logic [22:0] blocked_q;
    logic [22:0] blocked_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    // Address decode
    wire sel_timer = (ADDR == OFS_TIMER_PRIO);
    wire sel_serial = (ADDR == OFS_SERIAL_PRIO);
    wire sel_pwm_adc = (ADDR == OFS_PWM_ADC_PRIO);
    wire sel_blk_lo = (ADDR == OFS_BLOCKED_LO);
    wire sel_blk_hi = (ADDR == OFS_BLOCKED_HI);

    wire wr_timer = WR & sel_timer;
    wire wr_serial = WR & sel_serial;
    wire wr_pwm_adc = WR & sel_pwm_adc;
    wire wr_blk_lo = WR & sel_blk_lo;
    wire wr_blk_hi = WR & sel_blk_hi;

    // Only the documented field bits take write data
    assign timer_prio_d = wr_timer ? (WDATA & MASK_TIMER_PRIO) : timer_prio_q;
    assign serial_prio_d = wr_serial ? (WDATA & MASK_SERIAL_PRIO) : serial_prio_q; // RULE4
    assign pwm_adc_prio_d = wr_pwm_adc ? (WDATA & MASK_PWM_ADC_PRIO) : pwm_adc_prio_q;

    // Named fields, offset 7
    wire [1:0] timer_a_ch0_level = timer_prio_q[POS_TIMER_A_CH0 +: 2]; // RULE5
    wire [1:0] timer_b_ch3_level = timer_prio_q[POS_TIMER_B_CH3 +: 2]; // RULE6
    wire [1:0] timer_b_ch2_level = timer_prio_q[POS_TIMER_B_CH2 +: 2]; // RULE6
    wire [1:0] timer_b_ch1_level = timer_prio_q[POS_TIMER_B_CH1 +: 2]; // RULE6
    wire [1:0] timer_b_ch0_level = timer_prio_q[POS_TIMER_B_CH0 +: 2]; // RULE6
    wire [1:0] timer_c_ch3_level = timer_prio_q[POS_TIMER_C_CH3 +: 2]; // RULE7
    wire [1:0] timer_c_ch2_level = timer_prio_q[POS_TIMER_C_CH2 +: 2]; // RULE7
    wire [1:0] timer_c_ch1_level = timer_prio_q[POS_TIMER_C_CH1 +: 2]; // RULE7

    // Named fields, offset 8
    wire [1:0] serial0_rx_full_level = serial_prio_q[POS_SERIAL0_RX_FULL +: 2]; // RULE8
    wire [1:0] serial0_rx_error_level = serial_prio_q[POS_SERIAL0_RX_ERROR +: 2]; // RULE8
    wire [1:0] serial0_tx_idle_level = serial_prio_q[POS_SERIAL0_TX_IDLE +: 2]; // RULE9
    wire [1:0] serial0_tx_empty_level = serial_prio_q[POS_SERIAL0_TX_EMPTY +: 2]; // RULE9
    wire [1:0] timer_a_ch3_level = serial_prio_q[POS_TIMER_A_CH3 +: 2]; // RULE10
    wire [1:0] timer_a_ch2_level = serial_prio_q[POS_TIMER_A_CH2 +: 2]; // RULE10
    wire [1:0] timer_a_ch1_level = serial_prio_q[POS_TIMER_A_CH1 +: 2]; // RULE10

    // Named fields, offset 9
    wire [1:0] pwm_a_fault_level = pwm_adc_prio_q[POS_PWM_A_FAULT +: 2]; // RULE11
    wire [1:0] pwm_b_fault_level = pwm_adc_prio_q[POS_PWM_B_FAULT +: 2]; // RULE11
    wire [1:0] pwm_a_reload_level = pwm_adc_prio_q[POS_PWM_A_RELOAD +: 2]; // RULE12
    wire [1:0] pwm_b_reload_level = pwm_adc_prio_q[POS_PWM_B_RELOAD +: 2]; // RULE12
    wire [1:0] adc_a_zero_cross_level = pwm_adc_prio_q[POS_ADC_A_ZERO_CROSS +: 2]; // RULE13
    wire [1:0] adc_b_zero_cross_level = pwm_adc_prio_q[POS_ADC_B_ZERO_CROSS +: 2]; // RULE13
    wire [1:0] adc_a_conv_done_level = pwm_adc_prio_q[POS_ADC_A_CONV_DONE +: 2]; // RULE14
    wire [1:0] adc_b_conv_done_level = pwm_adc_prio_q[POS_ADC_B_CONV_DONE +: 2]; // RULE14

    // Source index i takes bits 2i+1:2i; index 0 is timer A channel 0
    wire [2*NUM_SRC-1:0] src_levels = {
        adc_b_conv_done_level,
        adc_a_conv_done_level,
        adc_b_zero_cross_level,
        adc_a_zero_cross_level,
        pwm_b_reload_level,
        pwm_a_reload_level,
        pwm_b_fault_level,
        pwm_a_fault_level,
        timer_a_ch1_level,
        timer_a_ch2_level,
        timer_a_ch3_level,
        serial0_tx_empty_level,
        serial0_tx_idle_level,
        serial0_rx_error_level,
        serial0_rx_full_level,
        timer_c_ch1_level,
        timer_c_ch2_level,
        timer_c_ch3_level,
        timer_b_ch0_level,
        timer_b_ch1_level,
        timer_b_ch2_level,
        timer_b_ch3_level,
        timer_a_ch0_level
    };

    // A source whose field holds the disabled code
    logic [NUM_SRC-1:0] src_off;
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_off
        assign src_off[i] = (src_levels[2*i +: 2] == LVL_OFF);
    end

    // Blocked record: write 1 clears, but a new hit in that same cycle wins
    wire [22:0] blk_hit = SRC_REQ & src_off; // RULE15
    wire [22:0] blk_clr = {wr_blk_hi ? WDATA[6:0] : 7'h00, wr_blk_lo ? WDATA : 16'h0000};
    assign blocked_d = (blocked_q & ~blk_clr) | blk_hit;

    // Router: one registered stage between request and level outputs
    logic [NUM_SRC-1:0] lvl0_q;
    logic [NUM_SRC-1:0] lvl1_q;
    logic [NUM_SRC-1:0] lvl2_q;
    logic [2:0] any_q;
    logic [1:0] top_q;

    irqp_route #(
        .N(NUM_SRC)
    ) u_route (
        .clk(CLK),
        .rst_n(RSTN),
        .req(SRC_REQ),
        .levels(src_levels),
        .lvl0_q(lvl0_q),
        .lvl1_q(lvl1_q),
        .lvl2_q(lvl2_q),
        .any_q(any_q),
        .top_q(top_q)
    );

    // Read mux; unmapped offsets and the reserved hole read as zero
    always_comb begin
        rdata_d = 16'h0000;
        if (RD) begin
            case (ADDR)
                OFS_TIMER_PRIO: rdata_d = timer_prio_q;
                OFS_SERIAL_PRIO: rdata_d = serial_prio_q & MASK_SERIAL_PRIO; // RULE4
                OFS_PWM_ADC_PRIO: rdata_d = pwm_adc_prio_q;
                OFS_LVL0_LO: rdata_d = lvl0_q[15:0];
                OFS_LVL0_HI: rdata_d = {9'h000, lvl0_q[22:16]};
                OFS_LVL1_LO: rdata_d = lvl1_q[15:0];
                OFS_LVL1_HI: rdata_d = {9'h000, lvl1_q[22:16]};
                OFS_LVL2_LO: rdata_d = lvl2_q[15:0];
                OFS_LVL2_HI: rdata_d = {9'h000, lvl2_q[22:16]};
                OFS_BLOCKED_LO: rdata_d = blocked_q[15:0];
                OFS_BLOCKED_HI: rdata_d = {9'h000, blocked_q[22:16]};
                OFS_SUMMARY: rdata_d = {11'h000, top_q, any_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Every field starts disabled
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            timer_prio_q <= RST_TIMER_PRIO; // RULE3
            serial_prio_q <= RST_SERIAL_PRIO; // RULE3
            pwm_adc_prio_q <= RST_PWM_ADC_PRIO; // RULE3
            blocked_q <= RST_BLOCKED;
            rdata_q <= 16'h0000;
        end else begin
            timer_prio_q <= timer_prio_d;
            serial_prio_q <= serial_prio_d;
            pwm_adc_prio_q <= pwm_adc_prio_d;
            blocked_q <= blocked_d;
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;
    assign LVL0_REQ = lvl0_q;
    assign LVL1_REQ = lvl1_q;
    assign LVL2_REQ = lvl2_q;
    assign LVL_ANY = any_q;
    assign LVL_TOP = top_q;

endmodule : irqp_top

// ===== irqp_pkg.sv
/*
 * Package for the interrupt priority configuration block: register offsets,
 * field positions, reset values and the priority field decode shared by the
 * register file and the request router.
 * Assumes a single 25 MHz system clock and a plain strobe register port.
 */
// Overview of operation
// RULE1 - Field codes: 00 off, 01/10/11 levels 0-2
// RULE2 - No source may exceed priority level 2
// RULE3 - Reset clears every priority field to zero
// RULE4 - Offset 8 bits 11-10 read zero, unwritable
// RULE5 - Offset 7 bits 15-14: timer A channel 0
// RULE6 - Offset 7 bits 13-6: timer B channels 3-0
// RULE7 - Offset 7 bits 5-0: timer C channels 3-1
// RULE8 - Offset 8 bits 15-12: serial 0 receive full/error
// RULE9 - Offset 8 bits 9-6: serial 0 transmit idle/empty
// RULE10 - Offset 8 bits 5-0: timer A channels 3-1
// RULE11 - Offset 9 bits 15-12: PWM A/B fault
// RULE12 - Offset 9 bits 11-8: PWM A/B reload
// RULE13 - Offset 9 bits 7-4: ADC A/B zero crossing
// RULE14 - Offset 9 bits 3-0: ADC A/B conversion complete
// RULE15 - Forward requests at programmed level; suppress when disabled
package irqp_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_SRC = 23;

    // Register offsets (word addresses on the register port)
    localparam logic [4:0] OFS_TIMER_PRIO = 5'h07;
    localparam logic [4:0] OFS_SERIAL_PRIO = 5'h08;
    localparam logic [4:0] OFS_PWM_ADC_PRIO = 5'h09;
    localparam logic [4:0] OFS_LVL0_LO = 5'h10;
    localparam logic [4:0] OFS_LVL0_HI = 5'h11;
    localparam logic [4:0] OFS_LVL1_LO = 5'h12;
    localparam logic [4:0] OFS_LVL1_HI = 5'h13;
    localparam logic [4:0] OFS_LVL2_LO = 5'h14;
    localparam logic [4:0] OFS_LVL2_HI = 5'h15;
    localparam logic [4:0] OFS_BLOCKED_LO = 5'h16;
    localparam logic [4:0] OFS_BLOCKED_HI = 5'h17;
    localparam logic [4:0] OFS_SUMMARY = 5'h18;

    // Reset values
    localparam logic [15:0] RST_TIMER_PRIO = 16'h0000;
    localparam logic [15:0] RST_SERIAL_PRIO = 16'h0000;
    localparam logic [15:0] RST_PWM_ADC_PRIO = 16'h0000;
    localparam logic [22:0] RST_BLOCKED = 23'h000000;

    // Writable bits; the serial register has a hole at bits 11-10
    localparam logic [15:0] MASK_TIMER_PRIO = 16'hffff;
    localparam logic [15:0] MASK_SERIAL_PRIO = 16'hf3ff;
    localparam logic [15:0] MASK_PWM_ADC_PRIO = 16'hffff;

    // Field low-bit positions, offset 7
    localparam int POS_TIMER_A_CH0 = 14;
    localparam int POS_TIMER_B_CH3 = 12;
    localparam int POS_TIMER_B_CH2 = 10;
    localparam int POS_TIMER_B_CH1 = 8;
    localparam int POS_TIMER_B_CH0 = 6;
    localparam int POS_TIMER_C_CH3 = 4;
    localparam int POS_TIMER_C_CH2 = 2;
    localparam int POS_TIMER_C_CH1 = 0;
    // Offset 8
    localparam int POS_SERIAL0_RX_FULL = 14;
    localparam int POS_SERIAL0_RX_ERROR = 12;
    localparam int POS_SERIAL0_TX_IDLE = 8;
    localparam int POS_SERIAL0_TX_EMPTY = 6;
    localparam int POS_TIMER_A_CH3 = 4;
    localparam int POS_TIMER_A_CH2 = 2;
    localparam int POS_TIMER_A_CH1 = 0;
    // Offset 9
    localparam int POS_PWM_A_FAULT = 14;
    localparam int POS_PWM_B_FAULT = 12;
    localparam int POS_PWM_A_RELOAD = 10;
    localparam int POS_PWM_B_RELOAD = 8;
    localparam int POS_ADC_A_ZERO_CROSS = 6;
    localparam int POS_ADC_B_ZERO_CROSS = 4;
    localparam int POS_ADC_A_CONV_DONE = 2;
    localparam int POS_ADC_B_CONV_DONE = 0;

    // Field encodings
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_0 = 2'h1;
    localparam logic [1:0] LVL_1 = 2'h2;
    localparam logic [1:0] LVL_2 = 2'h3;

    // One-hot {level2, level1, level0}; disabled code gives none, and the
    // two-bit field simply cannot name anything above level 2
    function automatic logic [2:0] irqp_decode(input logic [1:0] fld);
        logic [2:0] oh;
        oh = 3'h0;
        case (fld)
            LVL_0: oh = 3'h1;
            LVL_1: oh = 3'h2;
            LVL_2: oh = 3'h4;
            default: oh = 3'h0;
        endcase
        return oh;
    endfunction : irqp_decode

    // Highest active level expressed in the field encoding, LVL_OFF if none
    function automatic logic [1:0] irqp_highest(input logic [2:0] any);
        logic [1:0] code;
        code = LVL_OFF;
        if (any[2]) begin
            code = LVL_2;
        end else if (any[1]) begin
            code = LVL_1;
        end else if (any[0]) begin
            code = LVL_0;
        end
        return code;
    endfunction : irqp_highest

endpackage : irqp_pkg

// ===== irqp_route.sv
/*
 * Request router: sorts each pending source request onto the level vector
 * its priority field selects, and summarises which levels are active.
 * Assumes requests and fields come from logic on the same clock.
 */
module irqp_route #(
    parameter int N = 23
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sources and their fields
    input wire logic [N-1:0] req,
    input wire logic [2*N-1:0] levels,
    // Sorted requests
    output logic [N-1:0] lvl0_q,
    output logic [N-1:0] lvl1_q,
    output logic [N-1:0] lvl2_q,
    output logic [2:0] any_q,
    output logic [1:0] top_q
);
    import irqp_pkg::*;

    logic [N-1:0] lvl0_d;
    logic [N-1:0] lvl1_d;
    logic [N-1:0] lvl2_d;
    logic [2:0] any_d;

    for (genvar i = 0; i < N; i++) begin : g_src
        wire [2:0] oh = irqp_decode(levels[2*i +: 2]); // RULE1 RULE2
        assign lvl0_d[i] = req[i] & oh[0]; // RULE15
        assign lvl1_d[i] = req[i] & oh[1]; // RULE15
        assign lvl2_d[i] = req[i] & oh[2]; // RULE15
    end

    assign any_d = {|lvl2_d, |lvl1_d, |lvl0_d};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl0_q <= '0;
            lvl1_q <= '0;
            lvl2_q <= '0;
            any_q <= 3'h0;
            top_q <= LVL_OFF;
        end else begin
            lvl0_q <= lvl0_d;
            lvl1_q <= lvl1_d;
            lvl2_q <= lvl2_d;
            any_q <= any_d;
            top_q <= irqp_highest(any_d);
        end
    end

endmodule : irqp_route

// ===== irqp_props.sv
/* Port-level checker for the priority configuration block.
   Assumes it is bound to irqp_top and sees only that module's ports. */
module irqp_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [4:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // Requests
    input wire logic [22:0] SRC_REQ,
    input wire logic [22:0] LVL0_REQ,
    input wire logic [22:0] LVL1_REQ,
    input wire logic [22:0] LVL2_REQ,
    input wire logic [2:0] LVL_ANY,
    input wire logic [1:0] LVL_TOP
);
    wire logic [22:0] all_lvl = LVL0_REQ | LVL1_REQ | LVL2_REQ;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    chk_hole_reads_zero: assert property (RD && ADDR == 5'h08 |=> RDATA[11:10] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_one_level: assert property ((LVL0_REQ & LVL1_REQ | LVL0_REQ & LVL2_REQ
        | LVL1_REQ & LVL2_REQ) == 23'h0) else $error("source on two levels");
    chk_req_follows: assert property (1'b1 |=> (all_lvl & ~$past(SRC_REQ)) == 23'h0)
        else $error("level request without source request");
    chk_any_summary: assert property (LVL_ANY == {|LVL2_REQ, |LVL1_REQ, |LVL0_REQ})
        else $error("level summary mismatch");
    chk_top_code: assert property (LVL_TOP == (LVL_ANY[2] ? 2'h3 : LVL_ANY[1] ? 2'h2
        : {1'b0, LVL_ANY[0]})) else $error("top level code wrong");
    chk_reset_clear: assert property ($rose(RSTN) |-> all_lvl == 23'h0
        && LVL_TOP == 2'h0 && RDATA == 16'h0) else $error("outputs not clear after reset");
    chk_tmr_a0_route: assert property (WR && ADDR == 5'h07 && WDATA == 16'hc000
        ##1 !WR && SRC_REQ[0] |=> LVL2_REQ[0]) else $error("timer A ch0 not at level 2");
    chk_pwm_adc_off: assert property (WR && ADDR == 5'h09 && WDATA == 16'h0
        ##1 !WR |=> all_lvl[22:15] == 8'h0) else $error("disabled source forwarded");
endmodule : irqp_props

bind irqp_top irqp_props chk_u (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SRC_REQ(SRC_REQ), .LVL0_REQ(LVL0_REQ), .LVL1_REQ(LVL1_REQ),
    .LVL2_REQ(LVL2_REQ), .LVL_ANY(LVL_ANY), .LVL_TOP(LVL_TOP));

// ===== irqp_core_model.sv
/* Core-side model: accepts the highest requested level each cycle.
   Assumes the level summary and top code come from irqp_top on one clock. */
module irqp_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level requests
    input wire logic [2:0] lvl_any,
    input wire logic [1:0] lvl_top,
    // Level last accepted
    output logic [1:0] taken_q
);
    // Holds while nothing is requested, so a stale top code is never taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_q <= 2'h0;
        end else if (|lvl_any) begin
            taken_q <= lvl_top;
        end
    end
endmodule : irqp_core_model

// ===== irqp_top_bench.sv
/* Self-checking bench for irqp_top: register access, routing of every source
   at every field code, and reset. Assumes the core model in its own file. */
module irqp_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import irqp_pkg::*;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [4:0] ADDR = 5'h0;
    logic [15:0] WDATA = 16'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [22:0] SRC_REQ = 23'h0;
    logic [15:0] RDATA;
    logic [22:0] LVL0_REQ;
    logic [22:0] LVL1_REQ;
    logic [22:0] LVL2_REQ;
    logic [2:0] LVL_ANY;
    logic [1:0] LVL_TOP;
    logic [1:0] taken;
    logic [15:0] d;
    int errors = 0;
    int n_checks = 0;
    irqp_top dut_u (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SRC_REQ(SRC_REQ), .LVL0_REQ(LVL0_REQ), .LVL1_REQ(LVL1_REQ),
        .LVL2_REQ(LVL2_REQ), .LVL_ANY(LVL_ANY), .LVL_TOP(LVL_TOP));
    irqp_core_model core_u (.clk(CLK), .rst_n(RSTN), .lvl_any(LVL_ANY), .lvl_top(LVL_TOP),
        .taken_q(taken));
    initial begin
        forever #20 CLK = ~CLK;
    end
    task automatic chk(input logic [68:0] seen, input logic [68:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask : rd
    task automatic rst();
        @(posedge CLK);
        RSTN <= 1'b0;
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
    endtask : rst
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // Offset and low bit of source i, following the request index map
    function automatic logic [4:0] src_ofs(input int i);
        return i < 8 ? 5'h07 : i < 15 ? 5'h08 : 5'h09;
    endfunction : src_ofs
    function automatic int src_pos(input int i);
        return i < 8 ? 14 - 2 * i : i < 10 ? 30 - 2 * i : i < 15 ? 28 - 2 * i : 44 - 2 * i;
    endfunction : src_pos
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        rst();
        for (int k = 7; k <= 9; k++) begin
            rd(5'(k), d);
            chk(d, 69'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 23; i++) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge CLK);
                SRC_REQ <= 23'h1 << i;
                wr(src_ofs(i), 16'(c << src_pos(i)));
                repeat (2) @(posedge CLK);
                #1;
                chk({LVL2_REQ, LVL1_REQ, LVL0_REQ},
                    c == 0 ? 69'h0 : 69'h1 << (i + 23 * (c - 1)));
                chk({LVL_TOP, LVL_ANY},
                    c == 0 ? 69'h0 : 69'(c * 8 + (1 << (c - 1))));
                if (c != 0) chk(taken, 69'(c));
            end
        end
        $display("test routing done");
        // Every source requested while its field was still off
        rd(OFS_BLOCKED_LO, d);
        chk(d, 69'hffff);
        rd(OFS_BLOCKED_HI, d);
        chk(d, 69'h7f);
        wr(OFS_BLOCKED_LO, 16'hffff);
        wr(OFS_BLOCKED_HI, 16'h007f);
        rd(OFS_BLOCKED_LO, d);
        chk(d, 69'h0);
        rd(OFS_BLOCKED_HI, d);
        chk(d, 69'h0);
        wr(5'h07, 16'hffff);
        wr(5'h08, 16'hffff);
        wr(5'h09, 16'hffff);
        rd(5'h07, d);
        chk(d, 69'hffff);
        rd(5'h08, d);
        chk(d, 69'hf3ff);
        rd(5'h09, d);
        chk(d, 69'hffff);
        rd(5'h1f, d);
        chk(d, 69'h0);
        // Source 22 is still requesting and now sits at level 2
        rd(OFS_LVL2_HI, d);
        chk(d, 69'h40);
        // Level views are read-only
        wr(OFS_LVL2_HI, 16'h0000);
        rd(OFS_LVL2_HI, d);
        chk(d, 69'h40);
        rd(OFS_SUMMARY, d);
        chk(d, 69'h1c);
        // Read data stand for one cycle only
        @(posedge CLK);
        #1;
        chk(RDATA, 69'h0);
        wr(5'h09, 16'h0002);
        rd(OFS_LVL1_HI, d);
        chk(d, 69'h40);
        wr(5'h09, 16'h0001);
        rd(OFS_LVL0_HI, d);
        chk(d, 69'h40);
        $display("test register access done");
        rst();
        for (int k = 7; k <= 9; k++) begin
            rd(5'(k), d);
            chk(d, 69'h0);
        end
        $display("test second reset done");
        wrap_up();
    end
endmodule : irqp_top_bench
